// *** hdl/vcf_consts.svh ***
/*
  Constants of the video comb input front end: sample widths, second line
  store partition, pipeline latency and default line length.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef VCF_CONSTS_SVH
`define VCF_CONSTS_SVH

// pixel sample width and signed high band width
`define VCF_DATA_W 10
`define VCF_HIGH_W 11
// second line store width and its two partitions
`define VCF_STORE_W 16
`define VCF_LOW_KEEP 5
`define VCF_SPLIT_EQ 8
// pipeline latency in pixels and stages built before the pad delay
`define VCF_LAT_PIX 40
`define VCF_PIPE_STAGES 4
// default samples per line of the line stores
`define VCF_LINE_LEN 858
// two-entry output buffer depth
`define VCF_BUF_DEPTH 2

`endif

// *** hdl/vcf_pkg.sv ***
/*
  Types shared by the video comb front end modules.
  Assumes vcf_consts.svh is on the include path.
*/
`include "vcf_consts.svh"

package vcf_pkg;
  typedef logic [`VCF_DATA_W-1:0] vcf_pix_t;
  typedef logic signed [`VCF_HIGH_W-1:0] vcf_hb_t;
  typedef logic [`VCF_STORE_W-1:0] vcf_store_t;
endpackage

// *** hdl/vcf_line_delay.sv ***
/*
  One video line store: a circular array delaying a word by LEN advances.
  Assumes a single pixel clock and an advance strobe from the same domain.
*/
`timescale 1ns/1ps
`default_nettype none

module vcf_line_delay #(
  parameter int W = 16,
  parameter int LEN = 858
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // one slot fewer than the line, since the output register adds the last advance
  localparam int DEPTH = LEN - 1;
  localparam int PTR_W = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_q;
  logic [W-1:0] q_q;
  logic primed_q;

  // write pointer wraps at the ring depth
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_q <= '0;
    end else if (i_en) begin
      ptr_q <= (ptr_q == PTR_W'(DEPTH - 1)) ? '0 : ptr_q + 1'b1;
    end
  end

  // primed once every slot holds a word of this run; until then the tap reads zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      primed_q <= 1'b0;
    end else if (i_en && ptr_q == PTR_W'(DEPTH - 1)) begin
      primed_q <= 1'b1;
    end
  end

  // storage has no reset; the primed flag hides stale slots
  always_ff @(posedge i_clk) begin
    if (i_en) begin
      mem[ptr_q] <= i_d;
    end
  end

  // read before write: DEPTH slots plus this register give LEN advances
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_q <= '0;
    end else if (i_en) begin
      q_q <= primed_q ? mem[ptr_q] : '0;
    end
  end

  assign o_q = q_q;

  ptr_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_en && ptr_q == PTR_W'(DEPTH - 1) |=> ptr_q == '0)
    else $error("line store pointer failed to wrap");

endmodule // vcf_line_delay

`default_nettype wire

// *** hdl/vcf_front_end.sv ***
/*
  Video comb input front end: input routing, complementary bandsplit,
  per-tap low/high/full bands, two line stores, passthrough selection,
  latency pad and a two-entry output buffer.
  Assumes one pixel clock, video pins from outside the domain and
  control bits held steady by a host on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vcf_consts.svh"

module vcf_front_end #(
  parameter int LINE_LEN = `VCF_LINE_LEN
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire vcf_pkg::vcf_pix_t i_video_a,
  input wire vcf_pkg::vcf_pix_t i_video_b,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic i_route_swap,
  input wire logic i_msb_invert_ctl,
  input wire logic i_lowpass_response_select,
  input wire logic i_comb_source_select,
  input wire logic i_line_store_split,
  input wire logic i_line_delay_input_select,
  input wire logic i_first_line_delay_bypass,
  input wire logic i_component_input_mode,
  input wire logic i_three_line_comb,
  output vcf_pkg::vcf_pix_t o_tap0_low,
  output vcf_pkg::vcf_hb_t o_tap0_high,
  output vcf_pkg::vcf_pix_t o_tap0_full,
  output vcf_pkg::vcf_pix_t o_tap1_low,
  output vcf_pkg::vcf_hb_t o_tap1_high,
  output vcf_pkg::vcf_pix_t o_tap1_full,
  output vcf_pkg::vcf_pix_t o_tap2_low,
  output vcf_pkg::vcf_hb_t o_tap2_high,
  output vcf_pkg::vcf_pix_t o_tap2_full,
  output vcf_pkg::vcf_hb_t o_comb_tap0,
  output vcf_pkg::vcf_hb_t o_comb_tap1,
  output vcf_pkg::vcf_hb_t o_comb_tap2,
  output vcf_pkg::vcf_pix_t o_passthrough_tap,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  import vcf_pkg::*;

  localparam int PIX = `VCF_DATA_W;
  localparam int HB = `VCF_HIGH_W;
  localparam int ST = `VCF_STORE_W;
  localparam int LK = `VCF_LOW_KEEP;
  localparam int EQ = `VCF_SPLIT_EQ;
  localparam int PAD = `VCF_LAT_PIX - `VCF_PIPE_STAGES;
  localparam int WORD_W = 3 * (2 * PIX + HB) + 3 * HB + PIX;
  localparam logic [5:0] FILL = 6'(`VCF_LAT_PIX);
  localparam logic [1:0] DEPTH = 2'(`VCF_BUF_DEPTH);

  // selectable low-pass: [1 2 1]/4 or [1 2 2 2 1]/8, both centred on t2
  function automatic vcf_pix_t lowpass(input vcf_pix_t t0, input vcf_pix_t t1, input vcf_pix_t t2,
                                       input vcf_pix_t t3, input vcf_pix_t t4, input logic wide);
    logic [PIX+2:0] acc;
    if (wide) begin
      acc = {3'h0, t0} + {2'h0, t1, 1'b0} + {2'h0, t2, 1'b0} + {2'h0, t3, 1'b0} + {3'h0, t4};
      return acc[PIX+2:3];
    end else begin
      acc = {3'h0, t1} + {2'h0, t2, 1'b0} + {3'h0, t3};
      return acc[PIX+1:2];
    end
  endfunction

  // complementary high band; low plus high always equals the centre
  function automatic vcf_hb_t highband(input vcf_pix_t centre, input vcf_pix_t low);
    return $signed({1'b0, centre}) - $signed({1'b0, low});
  endfunction

  // comb tap source: full band widened, or the high band
  function automatic vcf_hb_t comb_src(input logic luma, input vcf_hb_t hi, input vcf_pix_t full);
    return luma ? $signed({1'b0, full}) : hi;
  endfunction

  // pin synchronisers, free running
  vcf_pix_t a_m_q, a_s_q, b_m_q, b_s_q;
  logic v_m_q, v_s_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_m_q <= '0;
      a_s_q <= '0;
      b_m_q <= '0;
      b_s_q <= '0;
      v_m_q <= 1'b0;
      v_s_q <= 1'b0;
    end else begin
      a_m_q <= i_video_a;
      a_s_q <= a_m_q;
      b_m_q <= i_video_b;
      b_s_q <= b_m_q;
      v_m_q <= i_in_valid;
      v_s_q <= v_m_q;
    end
  end

  // whole pipeline stalls together when the buffer is full
  logic buf_ready, adv;
  assign adv = v_s_q & buf_ready;
  assign o_in_ready = buf_ready;

  // input processor: msb fix on the secondary pin, then path routing
  vcf_pix_t b_fix, pri_q, sec_q;
  assign b_fix = {b_s_q[PIX-1] ^ i_msb_invert_ctl, b_s_q[PIX-2:0]};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pri_q <= '0;
      sec_q <= '0;
    end else if (adv) begin
      pri_q <= i_route_swap ? b_fix : a_s_q;
      sec_q <= i_route_swap ? a_s_q : b_fix;
    end
  end

  // first line store, fed from either path, bypassable for field combs
  vcf_pix_t ld1_in, ld1_q, w1_in;
  assign ld1_in = i_line_delay_input_select ? sec_q : pri_q;
  assign w1_in = i_first_line_delay_bypass ? ld1_in : ld1_q;

  vcf_line_delay #(.W(PIX), .LEN(LINE_LEN)) u_first_line_delay (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(adv),
    .i_d(ld1_in),
    .o_q(ld1_q)
  );

  // filter windows; secondary feed delayed to the window centre
  vcf_pix_t w0_q [4];
  vcf_pix_t w1_q [4];
  vcf_pix_t sd_q [2];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        w0_q[i] <= '0;
        w1_q[i] <= '0;
      end
      sd_q[0] <= '0;
      sd_q[1] <= '0;
    end else if (adv) begin
      w0_q[0] <= pri_q;
      w1_q[0] <= w1_in;
      for (int i = 1; i < 4; i++) begin
        w0_q[i] <= w0_q[i-1];
        w1_q[i] <= w1_q[i-1];
      end
      sd_q[0] <= sec_q;
      sd_q[1] <= sd_q[0];
    end
  end

  // bandsplit of the undelayed and one-line taps
  vcf_pix_t low0_q, full0_q, low1_q, full1_q, sec_feed_q, lp0, lp1;
  vcf_hb_t high0_q, high1_q;
  assign lp0 = lowpass(pri_q, w0_q[0], w0_q[1], w0_q[2], w0_q[3], i_lowpass_response_select);
  assign lp1 = lowpass(w1_in, w1_q[0], w1_q[1], w1_q[2], w1_q[3], i_lowpass_response_select);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low0_q <= '0;
      high0_q <= '0;
      full0_q <= '0;
      low1_q <= '0;
      high1_q <= '0;
      full1_q <= '0;
      sec_feed_q <= '0;
    end else if (adv) begin
      low0_q <= lp0;
      high0_q <= highband(w0_q[1], lp0);
      full0_q <= w0_q[1];
      low1_q <= lp1;
      high1_q <= highband(w1_q[1], lp1);
      full1_q <= w1_q[1];
      sec_feed_q <= sd_q[1];
    end
  end

  // second line store packs bits as the split bit asks
  vcf_store_t ld2_in, ld2_q;
  assign ld2_in = i_line_store_split
                ? {high1_q[HB-1 -: EQ], low1_q[PIX-1 -: EQ]}
                : {high1_q, low1_q[PIX-1 -: LK]};

  vcf_line_delay #(.W(ST), .LEN(LINE_LEN)) u_second_line_delay (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(adv),
    .i_d(ld2_in),
    .o_q(ld2_q)
  );

  // unpack the two-line tap; dropped low bits come back as zero
  vcf_pix_t low2, full2;
  vcf_hb_t high2;
  logic signed [PIX+1:0] sum2;
  always_comb begin
    if (i_line_store_split) begin
      high2 = $signed({ld2_q[ST-1 -: EQ], {(HB - EQ){1'b0}}});
      low2 = {ld2_q[EQ-1:0], {(PIX - EQ){1'b0}}};
    end else begin
      high2 = $signed(ld2_q[ST-1 -: HB]);
      low2 = {ld2_q[LK-1:0], {(PIX - LK){1'b0}}};
    end
    sum2 = $signed({2'b00, low2}) + $signed({{(PIX + 2 - HB){high2[HB-1]}}, high2});
    // truncation can push the sum just outside range, so clamp it
    if (sum2[PIX+1]) begin
      full2 = '0;
    end else if (sum2[PIX]) begin
      full2 = '1;
    end else begin
      full2 = sum2[PIX-1:0];
    end
  end

  // passthrough selector: secondary, one-line or undelayed full band
  vcf_pix_t flat;
  assign flat = i_component_input_mode ? sec_feed_q : (i_three_line_comb ? full1_q : full0_q);

  logic [WORD_W-1:0] word_d;
  assign word_d = {low0_q, high0_q, full0_q, low1_q, high1_q, full1_q, low2, high2, full2,
                   comb_src(i_comb_source_select, high0_q, full0_q),
                   comb_src(i_comb_source_select, high1_q, full1_q),
                   comb_src(i_comb_source_select, high2, full2), flat};

  // latency pad; the one-line tap then sits a line plus forty back
  logic [WORD_W-1:0] pad_q [PAD];
  logic [5:0] fill_q;
  logic push;
  always_ff @(posedge i_clk) begin
    if (adv) begin
      pad_q[0] <= word_d;
      for (int i = 1; i < PAD; i++) begin
        pad_q[i] <= pad_q[i-1];
      end
    end
  end

  // words pushed only once the pad holds real samples
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_q <= '0;
    end else if (adv && fill_q != FILL) begin
      fill_q <= fill_q + 1'b1;
    end
  end
  assign push = adv && (fill_q == FILL);

  // two-entry output buffer; a receiver stall loses no word
  logic [WORD_W-1:0] fb_q [2];
  logic wp_q, rp_q, pop;
  logic [1:0] cnt_q;
  assign buf_ready = (cnt_q != DEPTH);
  assign o_out_valid = (cnt_q != 2'h0);
  assign pop = o_out_valid & i_out_ready;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fb_q[0] <= '0;
      fb_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        fb_q[wp_q] <= pad_q[PAD-1];
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  assign {o_tap0_low, o_tap0_high, o_tap0_full, o_tap1_low, o_tap1_high, o_tap1_full,
          o_tap2_low, o_tap2_high, o_tap2_full, o_comb_tap0, o_comb_tap1, o_comb_tap2,
          o_passthrough_tap} = fb_q[rp_q];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence adv_swap_off;
    adv && !i_route_swap;
  endsequence

  route_primary_a: assert property (adv_swap_off |=> pri_q == $past(a_s_q) && sec_q == $past(b_fix))
    else $error("primary path not taken from port a");
  msb_invert_a: assert property (adv_swap_off ##0 i_msb_invert_ctl |=> sec_q[PIX-1] != $past(b_s_q[PIX-1]))
    else $error("secondary msb not inverted");
  band_sum_a: assert property ($signed({2'b00, low1_q}) + $signed({{2{high1_q[HB-1]}}, high1_q})
                               == $signed({2'b00, full1_q}))
    else $error("bands do not sum to the input");
  flat_window_a: assert property (adv && w0_q[0] == w0_q[1] && w0_q[1] == w0_q[2] && w0_q[2] == w0_q[3]
                                  && pri_q == w0_q[0] |=> high0_q == '0)
    else $error("flat input leaves a high band");
  chroma_store_a: assert property (!i_line_store_split |-> ld2_in[ST-1 -: HB] == high1_q)
    else $error("chroma split dropped high band bits");
  bypass_path_a: assert property (i_first_line_delay_bypass && i_line_delay_input_select
                                  ##1 adv |=> w1_q[0] == $past(sec_q))
    else $error("bypassed tap not fed from secondary");
  component_flat_a: assert property (i_component_input_mode |-> word_d[PIX-1:0] == sec_feed_q)
    else $error("passthrough not secondary in component mode");
  push_after_fill_a: assert property (push |-> fill_q == FILL && cnt_q != DEPTH)
    else $error("word pushed before pad filled or into full buffer");
  full_stall_a: assert property (cnt_q == DEPTH && !pop |=> cnt_q == DEPTH)
    else $error("full buffer lost a word");

endmodule // vcf_front_end

`default_nettype wire

// *** verification/vcf_video_source.sv ***
/*
  Source model for the two video ports: random or impulse words with gaps.
  Assumes the front end's pixel clock and a view of its input ready.
*/
`timescale 1ns/1ps
`default_nettype none

module vcf_video_source (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_impulse,
  input wire logic i_ready,
  output vcf_pkg::vcf_pix_t o_video_a,
  output vcf_pkg::vcf_pix_t o_video_b,
  output logic o_valid
);
  import vcf_pkg::*;
  integer seed = 32;
  int sent = 0;
  int hold = 0;
  logic rdy;
  initial begin
    o_video_a = 10'h000;
    o_video_b = 10'h000;
    o_valid = 1'b0;
  end
  // port a carries the reference stream; the bench picks which side is primary
  // a refused word is held through the two-cycle sync lag
  always @(posedge i_clk) begin
    rdy = i_ready;
    #1;
    if (!rdy) hold = 3;
    if (!i_en || (hold == 0 && ($random(seed) & 3) == 0)) begin
      // idle pins toggle so a stale word cannot pass for a fresh one
      o_valid = 1'b0;
      o_video_a = ~o_video_a;
      o_video_b = ~o_video_b;
      if (!i_en) sent = 0;
      if (!i_en) hold = 0;
    end else if (hold > 0) begin
      hold = hold - 1;
    end else begin
      o_valid = 1'b1;
      o_video_a = i_impulse ? ((sent == 10) ? 10'h100 : 10'h000) : 10'($random(seed));
      o_video_b = 10'($random(seed));
      sent = sent + 1;
    end
  end
endmodule // vcf_video_source

`default_nettype wire

// *** verification/tb_video_comb_input_front_end.sv ***
/*
  Self-checking bench of the video comb front end, expectations from the taken stream.
  Assumes vcf_pkg, vcf_front_end and vcf_video_source are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_video_comb_input_front_end;
  import vcf_pkg::*;
  localparam int L = 8;
  typedef struct packed {
    vcf_pix_t l0; vcf_hb_t h0; vcf_pix_t f0; vcf_pix_t l1; vcf_hb_t h1; vcf_pix_t f1;
    vcf_pix_t l2; vcf_hb_t h2; vcf_pix_t f2; vcf_hb_t c0; vcf_hb_t c1; vcf_hb_t c2; vcf_pix_t pt;
  } vcf_obs_t;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic en = 1'b0;
  logic imp = 1'b0;
  logic i_out_ready = 1'b1;
  logic [8:0] cfg = 9'h000;
  vcf_pix_t va, vb, bb;
  logic iv, o_in_ready, o_out_valid;
  logic [20:0] s1 = 21'h000000;
  logic [20:0] s2 = 21'h000000;
  vcf_pix_t tl0, tf0, tl1, tf1, tl2, tf2, tpt;
  vcf_hb_t th0, th1, th2, tc0, tc1, tc2;
  vcf_pix_t pri[$];
  vcf_pix_t sec[$];
  vcf_obs_t obs[$];
  int refusals = 0;
  int err_count = 0;
  int checks_done = 0;
  integer seed = 32;

  // pixel clock, 25 ns
  initial forever #12.5 i_clk = ~i_clk;

  vcf_video_source i_src (.i_clk(i_clk), .i_en(en), .i_impulse(imp), .i_ready(o_in_ready),
    .o_video_a(va), .o_video_b(vb), .o_valid(iv));

  // cfg: swap inv lps css split line_delay_input_select byp comp three
  vcf_front_end #(.LINE_LEN(L)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_video_a(va), .i_video_b(vb),
    .i_in_valid(iv), .o_in_ready(o_in_ready), .i_route_swap(cfg[8]), .i_msb_invert_ctl(cfg[7]),
    .i_lowpass_response_select(cfg[6]), .i_comb_source_select(cfg[5]), .i_line_store_split(cfg[4]),
    .i_line_delay_input_select(cfg[3]), .i_first_line_delay_bypass(cfg[2]),
    .i_component_input_mode(cfg[1]), .i_three_line_comb(cfg[0]), .o_tap0_low(tl0), .o_tap0_high(th0),
    .o_tap0_full(tf0), .o_tap1_low(tl1), .o_tap1_high(th1), .o_tap1_full(tf1), .o_tap2_low(tl2),
    .o_tap2_high(th2), .o_tap2_full(tf2), .o_comb_tap0(tc0), .o_comb_tap1(tc1), .o_comb_tap2(tc2),
    .o_passthrough_tap(tpt), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready));

  // monitor: words taken after the sync lag, words popped; msb flip precedes routing
  always @(posedge i_clk) begin
    if (s2[20] && o_in_ready === 1'b1) begin
      bb = s2[9:0] ^ {cfg[7], 9'h000};
      pri.push_back(cfg[8] ? bb : s2[19:10]);
      sec.push_back(cfg[8] ? s2[19:10] : bb);
    end
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1)
      obs.push_back(vcf_obs_t'{tl0, th0, tf0, tl1, th1, tf1, tl2, th2, tf2, tc0, tc1, tc2, tpt});
    if (o_in_ready === 1'b0) refusals = refusals + 1;
    s2 = i_rst_n ? s1 : 21'h000000;
    s1 = i_rst_n ? {iv, va, vb} : 21'h000000;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int px(int i);
    return (i >= 0 && i < pri.size()) ? int'(pri[i]) : 0;
  endfunction

  // exact low band of an impulse stream for either response
  function automatic int lp(int k, logic sel);
    if (sel) return (px(k - 2) + px(k + 2) + 2 * (px(k - 1) + px(k) + px(k + 1))) / 8;
    return (px(k - 1) + px(k + 1) + 2 * px(k)) / 4;
  endfunction

  // two-line full band from the kept upper bits, clamped
  function automatic vcf_pix_t full2(vcf_pix_t l, vcf_hb_t h);
    int s;
    s = int'({l[9:2], 2'b00}) + int'($signed({h[10:3], 3'b000}));
    return (s < 0) ? 10'h000 : ((s > 1023) ? 10'h3FF : 10'(s));
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one test: reset, stream, drain, then compare every popped word
  task automatic run(input int t, input logic [8:0] c, input logic im, input int n, input bit stall);
    int k;
    int j;
    vcf_obs_t o;
    vcf_obs_t p;
    @(posedge i_clk);
    #1;
    i_rst_n = 1'b0;
    cfg = c;
    imp = im;
    repeat (2) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_clk);
    pri.delete();
    sec.delete();
    obs.delete();
    refusals = 0;
    #1;
    en = 1'b1;
    for (k = 0; k < n; k++) begin
      @(posedge i_clk);
      #1;
      i_out_ready = !stall || (k % 50 < 35 && ($random(seed) & 3) != 0);
    end
    en = 1'b0;
    i_out_ready = 1'b1;
    repeat (60) @(posedge i_clk);
    check(obs.size(), pri.size() - 40);
    check(refusals != 0, stall); // buffer refuses only while the receiver stalls
    for (k = 0; k < obs.size(); k++) begin
      o = obs[k];
      j = k - L;
      check(o.f0, pri[k]);
      check($signed({1'b0, o.l0}) + o.h0, {6'h00, o.f0});
      check(o.c0, c[5] ? vcf_hb_t'({1'b0, o.f0}) : o.h0);
      check(o.c1, c[5] ? vcf_hb_t'({1'b0, o.f1}) : o.h1);
      check(o.c2, c[5] ? vcf_hb_t'({1'b0, o.f2}) : o.h2);
      check(o.pt, c[1] ? sec[k] : (c[0] ? o.f1 : o.f0));
      if (im) check(o.l0, lp(k, c[6]));
      if (c[2]) check(o.f1, c[3] ? sec[k] : pri[k]);
      else if (j >= 0) begin
        p = obs[j];
        check(o.f1, c[3] ? sec[j] : pri[j]);
        if (!c[3]) check(o.h1, p.h0);
        if (j >= L && c[4]) check(o.f2, full2(p.l1, p.h1));
        if (j >= L && !c[4]) check(o.h2, p.h1);
        if (j >= L && !c[4]) check(o.l2[9:5], p.l1[9:5]);
      end
    end
    $display("test %0d done, %0d words", t, obs.size());
  endtask

  // watchdog, far beyond the roughly eleven hundred cycles the tests need
  initial begin
    #(25 * 20000);
    err_count = err_count + 1;
    final_report();
  end

  // composite runs choose comb inputs by comb source select alone
  initial begin
    repeat (2) @(posedge i_clk);
    run(1, 9'h000, 1'b0, 300, 1'b1);
    run(2, 9'h1FB, 1'b0, 200, 1'b1);
    run(3, 9'h0AD, 1'b0, 150, 1'b0); // field comb sets line input select and bypass
    run(4, 9'h000, 1'b1, 60, 1'b0);
    run(5, 9'h040, 1'b1, 60, 1'b0);
    final_report();
  end
endmodule // tb_video_comb_input_front_end

`default_nettype wire
